/* pls_pkg.sv */
// Package: constants and types for the programmable logic sequencer
package pls_pkg;
	localparam int NUM_INPUTS = 16;
	localparam int NUM_TERMS = 48;
	localparam int STATE_W = 6;
	localparam int OUT_W = 8;
	localparam int AND_W = 2 * (NUM_INPUTS + STATE_W);
	localparam int FF_W = STATE_W + OUT_W;
	localparam logic [STATE_W-1:0] STATE_RESET = 6'h3f;
	localparam logic [OUT_W-1:0] OUT_RESET = 8'hff;
	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic state_observe_select;
		logic state_load_select;
		logic output_load_select;
	} pls_diag_t;

	typedef struct packed {
		logic [OUT_W-1:0] out_val;
		logic [OUT_W-1:0] out_oe;
	} pls_pin_t;
endpackage

/* pls_term.sv */
// Single transition term: programmable AND of literals
`timescale 1ns/100ps
module pls_term #(
	parameter int W = pls_pkg::AND_W
) (
	// Literal vector, true and complement interleaved
	input wire logic [W-1:0] literals,
	// Connection mask, one bit per literal
	input wire logic [W-1:0] connect,
	// Term output
	output logic term
);
	// Intact true and complement pair forces zero, as an unprogrammed term does
	always_comb begin
		term = &(literals | ~connect);
	end
endmodule // pls_term

/* pls_sequencer.sv */
// Programmable logic sequencer core: arrays, registers, diagnostics, pins
`timescale 1ns/100ps
module pls_sequencer #(
	parameter int NUM_TERMS = pls_pkg::NUM_TERMS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Pins from outside
	input wire logic sequencer_clock,
	input wire logic [pls_pkg::NUM_INPUTS-1:0] logic_condition_inputs,
	input wire logic state_observe_hv,
	input wire logic state_load_hv,
	input wire logic output_load_hv,
	input wire logic shared_preset_enable_pin,
	input wire logic [pls_pkg::OUT_W-1:0] output_pins_in,
	// Static configuration store
	input wire logic option_output_enable,
	input wire logic [NUM_TERMS*pls_pkg::AND_W-1:0] and_connect,
	input wire logic [NUM_TERMS-1:0] complement_connect,
	input wire logic [NUM_TERMS-1:0] term_uses_complement,
	input wire logic [NUM_TERMS*pls_pkg::FF_W-1:0] set_connect,
	input wire logic [NUM_TERMS*pls_pkg::FF_W-1:0] reset_connect,
	// Pin drive
	output logic [pls_pkg::OUT_W-1:0] output_pins_out,
	output logic [pls_pkg::OUT_W-1:0] output_pins_oe,
	// Status
	output logic [pls_pkg::STATE_W-1:0] state_bits,
	output logic [pls_pkg::OUT_W-1:0] output_reg_bits,
	output logic undefined_result
);
	localparam int SW = pls_pkg::STATE_W;
	localparam int OW = pls_pkg::OUT_W;
	localparam int NI = pls_pkg::NUM_INPUTS;
	localparam int AW = pls_pkg::AND_W;
	localparam int FW = pls_pkg::FF_W;
	localparam int SYNC_W = 1 + NI + 3 + 1 + OW;

	// More terms would only slow the OR function for no documented gain
	if (NUM_TERMS < 1 || NUM_TERMS > 64) begin : g_bad_terms
		$error("NUM_TERMS out of range");
	end

	// Two-stage synchroniser for every pin input
	logic [SYNC_W-1:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
	// Synchronisers hold zeros after reset, which enable mode would read as enabled
	logic [1:0] settle_reg, settle_next;
	always_comb begin
		sync1_next = {sequencer_clock, logic_condition_inputs, state_observe_hv,
			state_load_hv, output_load_hv, shared_preset_enable_pin, output_pins_in};
		sync2_next = sync1_reg;
		settle_next = {settle_reg[0], 1'b1};
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			settle_reg <= '0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			settle_reg <= settle_next;
		end
	end

	logic ck_s;
	logic [NI-1:0] in_s;
	pls_pkg::pls_diag_t diag;
	logic shared_s;
	logic [OW-1:0] pins_s;
	assign {ck_s, in_s, diag, shared_s, pins_s} = sync2_reg;

	// Selects are separate digital flags; observe wins if several are up
	logic observe_on, sload_on, oload_on;
	assign observe_on = diag.state_observe_select;
	assign sload_on = diag.state_load_select && !observe_on;
	assign oload_on = diag.output_load_select && !observe_on && !sload_on;

	// Shared pin acts as preset unless enable option chosen; reset value means no preset
	logic preset_on, oe_active;
	assign preset_on = !option_output_enable && shared_s;
	assign oe_active = option_output_enable ? (!shared_s && settle_reg[1]) : 1'b1;

	// Diagnostic selects leave the array as normal inputs at logic levels
	logic [NI+SW-1:0] and_src;
	logic [SW-1:0] state_reg, state_next;
	logic [OW-1:0] out_reg, out_next;
	assign and_src = {state_reg, in_s};

	logic [AW-1:0] literals;
	always_comb begin
		literals = '0;
		for (int i = 0; i < NI + SW; i++) begin
			literals[2*i] = and_src[i];
			literals[2*i+1] = !and_src[i];
		end
	end

	// AND array; config is static so no retiming of it is attempted
	logic [NUM_TERMS-1:0] raw_term;
	genvar g;
	generate
		for (g = 0; g < NUM_TERMS; g++) begin : g_term
			pls_term #(.W(AW)) u_term (
				.literals(literals),
				.connect(and_connect[g*AW +: AW]),
				.term(raw_term[g])
			);
		end
	endgenerate

	// Complement array: else term held low while any chosen term is active
	logic comp_line;
	logic [NUM_TERMS-1:0] term;
	always_comb begin
		comp_line = ~|(raw_term & complement_connect);
		term = raw_term & ~(term_uses_complement & {NUM_TERMS{~comp_line}});
	end

	// OR array onto set and reset of every flip-flop
	function automatic logic [FW-1:0] or_plane(input logic [NUM_TERMS-1:0] t,
			input logic [NUM_TERMS*FW-1:0] conn);
		logic [FW-1:0] acc;
		acc = '0;
		for (int n = 0; n < NUM_TERMS; n++) begin
			acc = acc | (conn[n*FW +: FW] & {FW{t[n]}});
		end
		return acc;
	endfunction

	logic [FW-1:0] set_v, rst_v;
	assign set_v = or_plane(term, set_connect);
	assign rst_v = or_plane(term, reset_connect);

	// Set and reset together holds the bit; the part leaves that case undefined
	function automatic logic [FW-1:0] sr_update(input logic [FW-1:0] q, input logic [FW-1:0] s,
			input logic [FW-1:0] r);
		return (q & ~(r & ~s)) | (s & ~r);
	endfunction

	logic [FW-1:0] sr_v;
	assign sr_v = sr_update({out_reg, state_reg}, set_v, rst_v);

	// Rising clock detect, with lockout until a fall after preset
	logic ck_d_reg, ck_d_next, armed_reg, armed_next, rise;
	always_comb begin
		ck_d_next = ck_s;
		rise = ck_s && !ck_d_reg && armed_reg;
		armed_next = armed_reg;
		if (preset_on) begin
			armed_next = 1'b0;
		end else if (!ck_s && ck_d_reg) begin
			armed_next = 1'b1;
		end
	end

	// Set-reset flip-flops; both active gives a documented-undefined result
	logic undef_reg, undef_next;
	always_comb begin
		state_next = state_reg;
		out_next = out_reg;
		undef_next = undef_reg;
		if (preset_on) begin
			state_next = pls_pkg::STATE_RESET;
			out_next = pls_pkg::OUT_RESET;
			undef_next = 1'b0;
		end else if (rise) begin
			if (sload_on) begin
				state_next = pins_s[SW-1:0];
			end else if (oload_on) begin
				out_next = pins_s;
			end else if (!observe_on) begin
				// Both active: hold value, flag it, since the part gives no answer
				state_next = sr_v[SW-1:0];
				out_next = sr_v[FW-1:SW];
				undef_next = |(set_v & rst_v);
			end
		end
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= pls_pkg::STATE_RESET;
			out_reg <= pls_pkg::OUT_RESET;
			undef_reg <= 1'b0;
			ck_d_reg <= 1'b0;
			armed_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			out_reg <= out_next;
			undef_reg <= undef_next;
			ck_d_reg <= ck_d_next;
			armed_reg <= armed_next;
		end
	end

	// Pin drive, registered so outputs lag the selects by one cycle
	pls_pkg::pls_pin_t pin_reg, pin_next;
	always_comb begin
		pin_next.out_val = out_reg;
		pin_next.out_oe = {OW{oe_active}};
		if (preset_on) begin
			pin_next.out_val = pls_pkg::OUT_RESET;
		end
		if (sload_on || oload_on) begin
			pin_next.out_oe = '0;
		end else if (observe_on) begin
			pin_next.out_val = {out_reg[OW-1:SW], state_reg};
		end
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_reg.out_val <= pls_pkg::OUT_RESET;
			pin_reg.out_oe <= '0;
		end else begin
			pin_reg <= pin_next;
		end
	end

	assign output_pins_out = pin_reg.out_val;
	assign output_pins_oe = pin_reg.out_oe;
	assign state_bits = state_reg;
	assign output_reg_bits = out_reg;
	assign undefined_result = undef_reg;
endmodule // pls_sequencer

/* pls_sequencer_asserts.sv */
// Port-level checks for the sequencer
`timescale 1ns/100ps
module pls_sequencer_asserts (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Pins and option
	input wire logic sequencer_clock,
	input wire logic state_observe_hv,
	input wire logic state_load_hv,
	input wire logic output_load_hv,
	input wire logic shared_preset_enable_pin,
	input wire logic option_output_enable,
	// Outputs
	input wire logic [pls_pkg::OUT_W-1:0] output_pins_out,
	input wire logic [pls_pkg::OUT_W-1:0] output_pins_oe,
	input wire logic [pls_pkg::STATE_W-1:0] state_bits,
	input wire logic [pls_pkg::OUT_W-1:0] output_reg_bits
);
	logic prs;
	logic diag;
	assign prs = shared_preset_enable_pin & ~option_output_enable;
	assign diag = state_observe_hv | state_load_hv | output_load_hv;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Long windows ride out the input synchronisers
	AST_EDGE: assert property (($stable(sequencer_clock) && !prs)[*5] |->
		$stable(state_bits) && $stable(output_reg_bits)) else $error("registers moved without clock");
	AST_OBS: assert property ((state_observe_hv && !prs)[*4] |->
		output_pins_out[5:0] == $past(state_bits) && $stable(output_reg_bits)) else $error("observe");
	AST_SLOAD: assert property ((state_load_hv && !state_observe_hv && !prs)[*4] |->
		$stable(output_reg_bits) && output_pins_oe == 8'h00) else $error("state load");
	AST_OLOAD: assert property ((output_load_hv && !state_load_hv
		&& !state_observe_hv && !prs)[*4] |-> $stable(state_bits))
		else $error("output load touched state");
	AST_PRS: assert property (prs[*4] |-> state_bits == 6'h3f && output_reg_bits == 8'hff
		&& output_pins_out == 8'hff) else $error("preset");
	AST_HIZ: assert property ((option_output_enable && shared_preset_enable_pin)[*4] |->
		output_pins_oe == 8'h00) else $error("pins not released");
	AST_DRIVE: assert property ((!diag && !shared_preset_enable_pin)[*4] |-> output_pins_oe ==
		8'hff && output_pins_out == $past(output_reg_bits)) else $error("pins not output reg");
	AST_PWRUP: assert property ($rose(reset_n) |-> state_bits == 6'h3f &&
		output_reg_bits == 8'hff) else $error("power-up value");
	cover property (prs[*4]);
	cover property (state_load_hv[*4]);
	cover property (state_observe_hv[*4]);
endmodule // pls_sequencer_asserts
bind pls_sequencer pls_sequencer_asserts u_pls_sequencer_asserts (.core_clk(core_clk),
	.reset_n(reset_n), .sequencer_clock(sequencer_clock), .state_observe_hv(state_observe_hv),
	.state_load_hv(state_load_hv), .output_load_hv(output_load_hv),
	.shared_preset_enable_pin(shared_preset_enable_pin),
	.option_output_enable(option_output_enable), .output_pins_out(output_pins_out),
	.output_pins_oe(output_pins_oe), .state_bits(state_bits), .output_reg_bits(output_reg_bits));

/* pls_partner.sv */
// Surrounding logic: device clock pulses and pin drive
`timescale 1ns/100ps
module pls_partner (
	// Clock
	input wire logic core_clk,
	// From device
	input wire logic [7:0] pins_out,
	input wire logic [7:0] pins_oe,
	// To device
	output logic seq_clk,
	output logic [7:0] pins_in
);
	logic drv_en;
	logic [7:0] drv_val;
	// Undriven pins flip so a stale level never passes
	assign pins_in = (pins_oe & pins_out) | (~pins_oe & (drv_en ? drv_val : ~pins_out));
	initial begin
		seq_clk = 1'b0;
		drv_en = 1'b0;
		drv_val = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// High and low phases each longer than the sampling window
	task automatic pulse();
		tick(1);
		seq_clk = 1'b1;
		tick(4);
		seq_clk = 1'b0;
		tick(4);
	endtask
endmodule // pls_partner

/* pls_sequencer_tb_top.sv */
// Testbench top for the sequencer
`timescale 1ns/100ps
module pls_sequencer_tb_top;
	logic core_clk, reset_n, obs, sld, old, shp, opt, sclk;
	logic [15:0] cond;
	logic [7:0] pin, pout, poe, oreg;
	logic [5:0] st;
	logic [2111:0] and_cfg;
	logic [671:0] set_cfg, rst_cfg;
	logic [47:0] cmp_cfg, use_cmp;
	logic undef;
	int fails = 0;
	int checked = 0;
	pls_sequencer u_pls_sequencer (.core_clk(core_clk), .reset_n(reset_n),
		.sequencer_clock(sclk), .logic_condition_inputs(cond), .state_observe_hv(obs),
		.state_load_hv(sld), .output_load_hv(old), .shared_preset_enable_pin(shp),
		.output_pins_in(pin), .option_output_enable(opt), .and_connect(and_cfg),
		.complement_connect(cmp_cfg), .term_uses_complement(use_cmp), .set_connect(set_cfg),
		.reset_connect(rst_cfg), .output_pins_out(pout), .output_pins_oe(poe),
		.state_bits(st), .output_reg_bits(oreg), .undefined_result(undef));
	pls_partner u_pls_partner (.core_clk(core_clk), .pins_out(pout), .pins_oe(poe),
		.seq_clk(sclk), .pins_in(pin));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		if (fails == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		fails++;
		complete_run();
	end
	initial begin
		{reset_n, obs, sld, old, shp, opt, cond} = '0;
		and_cfg = '1;
		set_cfg = '0;
		rst_cfg = '0;
		cmp_cfg = '0;
		use_cmp = '0;
		repeat (16) @(posedge core_clk);
		#1 reset_n = 1'b1;
		u_pls_partner.tick(2);
		check({st, oreg}, 14'h3fff);
		u_pls_partner.pulse();
		check({st, oreg}, 14'h3fff);
		check(poe, 8'hff);
		// Term 0 on input 0 clears bit 0 of both, term 1 on its complement sets them
		and_cfg[87:0] = {44'h2, 44'h1};
		set_cfg[27:14] = 14'h41;
		rst_cfg[13:0] = 14'h41;
		cond[0] = 1'b1;
		u_pls_partner.pulse();
		check({st, oreg}, 14'h3efe);
		check(pout, 8'hfe);
		cond[0] = 1'b0;
		u_pls_partner.pulse();
		check({st, oreg}, 14'h3fff);
		cond[0] = 1'b1;
		sld = 1'b1;
		u_pls_partner.drv_val = 8'h15;
		u_pls_partner.drv_en = 1'b1;
		// Pins must be released and driven before the clock arrives
		u_pls_partner.tick(4);
		u_pls_partner.pulse();
		check(poe, 8'h00);
		check({st, oreg}, 14'h15ff);
		sld = 1'b0;
		old = 1'b1;
		u_pls_partner.drv_val = 8'ha5;
		u_pls_partner.pulse();
		check({st, oreg}, {6'h15, 8'ha5});
		old = 1'b0;
		obs = 1'b1;
		u_pls_partner.drv_en = 1'b0;
		u_pls_partner.pulse();
		check(pout[5:0], 6'h15);
		check(oreg, 8'ha5);
		obs = 1'b0;
		shp = 1'b1;
		u_pls_partner.pulse();
		check({st, oreg, pout}, 22'h3fffff);
		shp = 1'b0;
		u_pls_partner.pulse();
		check({st, oreg}, 14'h3fff);
		u_pls_partner.pulse();
		check({st, oreg}, 14'h3efe);
		// Term 2 is the else of term 0 and clears output bit 7
		cmp_cfg[0] = 1'b1;
		use_cmp[2] = 1'b1;
		and_cfg[131:88] = 44'h0;
		rst_cfg[41:28] = 14'h2000;
		u_pls_partner.pulse();
		check({st, oreg}, 14'h3efe);
		cond[0] = 1'b0;
		u_pls_partner.pulse();
		check({st, oreg}, 14'h3f7f);
		check(undef, 1'b0);
		set_cfg[41:28] = 14'h2000;
		u_pls_partner.pulse();
		check(undef, 1'b1);
		reset_n = 1'b0;
		opt = 1'b1;
		u_pls_partner.tick(2);
		reset_n = 1'b1;
		shp = 1'b1;
		u_pls_partner.tick(5);
		check({poe, oreg}, 16'h00ff);
		check(undef, 1'b0);
		shp = 1'b0;
		u_pls_partner.tick(5);
		check(poe, 8'hff);
		complete_run();
	end
endmodule // pls_sequencer_tb_top
